// ==== hw/clk_ctrl.sv ====
// main clock select, PLL, slow-mode divider and RC trim with register port
//
// The strobed register port and the register addresses were decided locally.
module clk_ctrl #(
  parameter int STARTUP_CYC = clk_ctrl_pkg::STARTUP_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // option bits
  input  wire logic        opt_rc_en_i,
  input  wire logic        opt_pll_en_i,
  input  wire logic        opt_pll_x8_i,
  input  wire logic        opt_rop_i,
  // clock sources and power state
  input  wire logic        rc_clk_i,
  input  wire logic        ext_clk_i,
  input  wire logic        halt_i,
  // clock, trim code, lock flag and interrupt outputs
  output logic             osc_clk_o,
  output logic             cpu_clk_o,
  output logic             clk_out_o,
  output logic             clk_out_oe_o,
  output logic      [7:0]  rc_trim_o,
  output logic             pll_lock_flag_o,
  output logic             irq_o
);
  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [7:0]  rc_oscillator_trim_q;
  logic        clock_out_enable_q;
  logic        slow_mode_select_q;
  logic [7:0]  factory_trim_5v_q;
  logic [7:0]  factory_trim_3v_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [7:0]  rdata_q;
  logic        rop_prev_q;
  logic        erase_ev;
  logic        lock_ev;
  logic        wr_ctrl;
  logic        wr_trim;
  logic        wr_load;

  assign wr_ctrl  = wr_i && (addr_i == clk_ctrl_pkg::ADDR_CTRL);
  assign wr_trim  = wr_i && (addr_i == clk_ctrl_pkg::ADDR_TRIM);
  assign wr_load  = wr_i && (addr_i == clk_ctrl_pkg::ADDR_TRIM_LOAD);
  assign erase_ev = rop_prev_q && !opt_rop_i;

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  // bits 7:2 are not stored, so they always read back zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_out_enable_q <= clk_ctrl_pkg::RST_CTRL[clk_ctrl_pkg::BIT_CLK_OUT];
      slow_mode_select_q <= clk_ctrl_pkg::RST_CTRL[clk_ctrl_pkg::BIT_SLOW];
    end else if (wr_ctrl) begin
      clock_out_enable_q <= wdata_i[clk_ctrl_pkg::BIT_CLK_OUT];
      slow_mode_select_q <= wdata_i[clk_ctrl_pkg::BIT_SLOW];
    end
  end

  // ----------------------------------------------------------------------
  // trim register
  // ----------------------------------------------------------------------
  // the code goes straight to the oscillator, larger codes run slower
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_oscillator_trim_q <= clk_ctrl_pkg::RST_TRIM;
    end else if (wr_trim) begin
      rc_oscillator_trim_q <= wdata_i;
    end else if (wr_load && wdata_i[clk_ctrl_pkg::BIT_LOAD_5V]) begin
      rc_oscillator_trim_q <= factory_trim_5v_q;
    end else if (wr_load && wdata_i[clk_ctrl_pkg::BIT_LOAD_3V]) begin
      rc_oscillator_trim_q <= factory_trim_3v_q;
    end
  end

  // ----------------------------------------------------------------------
  // factory calibration bytes
  // ----------------------------------------------------------------------
  // limitation: true retention lives in the memory array; reset reloads defaults
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rop_prev_q        <= 1'b0;
      factory_trim_5v_q <= clk_ctrl_pkg::FACTORY_5V_DEF;
      factory_trim_3v_q <= clk_ctrl_pkg::FACTORY_3V_DEF;
    end else begin
      rop_prev_q <= opt_rop_i;
      if (erase_ev) begin
        factory_trim_5v_q <= clk_ctrl_pkg::ERASED_BYTE;
        factory_trim_3v_q <= clk_ctrl_pkg::ERASED_BYTE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // source selection and PLL
  // ----------------------------------------------------------------------
  logic        src_lvl;
  logic        src_prev_q;
  logic        src_edge;
  logic        src_rise;
  logic [7:0]  per_cnt_q;
  logic [7:0]  per_q;
  logic [7:0]  step;
  logic [7:0]  gen_cnt_q;
  logic        gen_tick;
  logic        pll_run;
  logic [31:0] start_cnt_q;
  logic        pll_ready_q;
  logic        osc_tick;

  // PLL input is the RC when enabled, else the external clock
  assign src_lvl  = opt_rc_en_i ? rc_clk_i : ext_clk_i;
  assign src_edge = src_lvl != src_prev_q;
  assign src_rise = src_lvl && !src_prev_q;
  assign pll_run  = opt_pll_en_i && !halt_i;
  // each source period holds 2*mult output edges
  assign step     = opt_pll_x8_i ? (per_q >> 4) : (per_q >> 3);
  assign gen_tick = pll_ready_q && (gen_cnt_q + 8'h01 >= step);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_prev_q <= 1'b0;
      per_cnt_q  <= 8'h00;
      per_q      <= 8'h00;
    end else begin
      src_prev_q <= src_lvl;
      if (src_rise) begin
        per_q     <= per_cnt_q + 8'h01;
        per_cnt_q <= 8'h00;
      end else if (per_cnt_q != clk_ctrl_pkg::PER_MAX) begin
        per_cnt_q <= per_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_cnt_q <= 8'h00;
    end else if (!pll_ready_q || gen_tick) begin
      gen_cnt_q <= 8'h00;
    end else begin
      gen_cnt_q <= gen_cnt_q + 8'h01;
    end
  end

  // start-up restarts on every reset and every exit from halt
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_cnt_q <= 32'h0;
      pll_ready_q <= 1'b0;
    end else if (!pll_run) begin
      start_cnt_q <= 32'h0;
      pll_ready_q <= 1'b0;
    end else if (!pll_ready_q) begin
      start_cnt_q <= start_cnt_q + 32'h1;
      pll_ready_q <= (start_cnt_q + 32'h1 >= 32'(STARTUP_CYC));
    end
  end

  assign lock_ev  = pll_run && !pll_ready_q && (start_cnt_q + 32'h1 >= 32'(STARTUP_CYC));
  assign osc_tick = opt_pll_en_i ? gen_tick : src_edge;

  // ----------------------------------------------------------------------
  // oscillator, CPU and clock-out outputs
  // ----------------------------------------------------------------------
  logic        osc_q;
  logic        cpu_q;
  logic        slow_eff_q;
  logic [4:0]  div_q;
  logic        cpu_toggle;
  logic        mode_switch;
  logic        clk_out_q;
  logic        clk_out_oe_q;

  assign cpu_toggle  = osc_tick && (!slow_eff_q || div_q == clk_ctrl_pkg::SLOW_LAST);
  // mode only changes on a falling CPU edge so no phase is cut short
  assign mode_switch = cpu_toggle && cpu_q && (slow_eff_q != slow_mode_select_q);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_q      <= 1'b0;
      cpu_q      <= 1'b0;
      slow_eff_q <= 1'b0;
      div_q      <= 5'h00;
    end else begin
      if (osc_tick) begin
        osc_q <= !osc_q;
      end
      if (cpu_toggle) begin
        cpu_q <= !cpu_q;
      end
      if (mode_switch) begin
        slow_eff_q <= slow_mode_select_q;
      end
      if (cpu_toggle || mode_switch) begin
        div_q <= 5'h00;
      end else if (osc_tick && slow_eff_q) begin
        div_q <= div_q + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_out_q    <= 1'b0;
      clk_out_oe_q <= 1'b0;
    end else begin
      clk_out_oe_q <= clock_out_enable_q;
      clk_out_q    <= clock_out_enable_q && (osc_tick ? !osc_q : osc_q);
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  logic [1:0] ev_vec;
  logic       irq_q;

  assign ev_vec = {erase_ev, lock_ev};

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= clk_ctrl_pkg::RST_IRQ;
      irq_mask_q <= clk_ctrl_pkg::RST_IRQ;
    end else begin
      if (wr_i && addr_i == clk_ctrl_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_i[1:0];
      end
      if (wr_i && addr_i == clk_ctrl_pkg::ADDR_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wdata_i[1:0]) | ev_vec;
      end else begin
        irq_stat_q <= irq_stat_q | ev_vec;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((irq_stat_q | ev_vec) & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (!rd_i) begin
      rdata_q <= 8'h00;
    end else begin
      case (addr_i)
        clk_ctrl_pkg::ADDR_CTRL:
          rdata_q <= {6'h00, clock_out_enable_q, slow_mode_select_q};
        clk_ctrl_pkg::ADDR_TRIM:      rdata_q <= rc_oscillator_trim_q;
        clk_ctrl_pkg::ADDR_INTEG:     rdata_q <= {7'h00, pll_ready_q};
        clk_ctrl_pkg::ADDR_IRQ_STAT:  rdata_q <= {6'h00, irq_stat_q};
        clk_ctrl_pkg::ADDR_IRQ_MASK:  rdata_q <= {6'h00, irq_mask_q};
        clk_ctrl_pkg::ADDR_F5V_A,
        clk_ctrl_pkg::ADDR_F5V_B:     rdata_q <= factory_trim_5v_q;
        clk_ctrl_pkg::ADDR_F3V_A,
        clk_ctrl_pkg::ADDR_F3V_B:     rdata_q <= factory_trim_3v_q;
        default:                      rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata_o         = rdata_q;
  assign osc_clk_o       = osc_q;
  assign cpu_clk_o       = cpu_q;
  assign clk_out_o       = clk_out_q;
  assign clk_out_oe_o    = clk_out_oe_q;
  assign rc_trim_o       = rc_oscillator_trim_q;
  assign pll_lock_flag_o = pll_ready_q;
  assign irq_o           = irq_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_trim_after_reset: assert property (
    @(posedge ref_clk_i) $rose(rst_n_i) |-> rc_trim_o == 8'hFF)
    else $error("trim not FFh after reset");

  a_trim_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_trim |=> rc_trim_o == $past(wdata_i))
    else $error("trim write not stored");

  a_factory_load: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_load && !wr_trim && wdata_i[0] |=> rc_trim_o == $past(factory_trim_5v_q))
    else $error("factory trim not loaded");

  a_rop_erase: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    erase_ev |=> factory_trim_5v_q == 8'hFF && factory_trim_3v_q == 8'hFF)
    else $error("factory bytes not erased");

  a_pll_withheld: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    opt_pll_en_i && !pll_ready_q |=> osc_clk_o == $past(osc_clk_o))
    else $error("PLL clock before start-up");

  a_lock_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    lock_ev |=> pll_lock_flag_o && irq_stat_q[0])
    else $error("lock flag not set");

  a_direct_source: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !opt_pll_en_i && src_edge |=> osc_clk_o != $past(osc_clk_o))
    else $error("source edge not passed");

  a_clk_out_follow: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !clock_out_enable_q |=> !clk_out_o && !clk_out_oe_o)
    else $error("clock out while disabled");

  a_slow_divide: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    slow_eff_q && osc_tick && div_q != 5'h1F |=> cpu_clk_o == $past(cpu_clk_o))
    else $error("slow clock toggled early");

  a_switch_falling: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(slow_eff_q) |-> $fell(cpu_clk_o))
    else $error("mode switched off a falling edge");
endmodule  // clk_ctrl

// ==== pkg/clk_ctrl_pkg.sv ====
// constants, register map and reset values of the main clock select and trim block
package clk_ctrl_pkg;
  // --------------------------------------------------------------------
  // register addresses
  // --------------------------------------------------------------------
  localparam logic [15:0] ADDR_CTRL      = 16'h0038;
  localparam logic [15:0] ADDR_TRIM      = 16'h0039;
  localparam logic [15:0] ADDR_INTEG     = 16'h003A;
  localparam logic [15:0] ADDR_IRQ_STAT  = 16'h003B;
  localparam logic [15:0] ADDR_IRQ_MASK  = 16'h003C;
  localparam logic [15:0] ADDR_TRIM_LOAD = 16'h003D;
  localparam logic [15:0] ADDR_F5V_A     = 16'h1000;
  localparam logic [15:0] ADDR_F3V_A     = 16'h1001;
  localparam logic [15:0] ADDR_F5V_B     = 16'hFFDE;
  localparam logic [15:0] ADDR_F3V_B     = 16'hFFDF;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int BIT_SLOW      = 0;
  localparam int BIT_CLK_OUT   = 1;
  localparam int BIT_LOCK      = 0;
  localparam int BIT_EV_LOCK   = 0;
  localparam int BIT_EV_ERASE  = 1;
  localparam int BIT_LOAD_5V   = 0;
  localparam int BIT_LOAD_3V   = 1;
  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_TRIM    = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] RST_IRQ     = 2'h0;
  // arbitrary factory calibration defaults
  localparam logic [7:0] FACTORY_5V_DEF = 8'h80;
  localparam logic [7:0] FACTORY_3V_DEF = 8'h90;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int STARTUP_US    = 1000;
  localparam int STARTUP_CYC   = STARTUP_US * CLK_MHZ;
  localparam logic [4:0] SLOW_LAST = 5'h1F;
  localparam logic [7:0] PER_MAX   = 8'hFF;
endpackage

// ==== verif/clk_ctrl_test.sv ====
// self-checking bench of the main clock select and trim block
module clk_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------------
  localparam int SU = 20;
  logic        ref_clk_i    = 1'b0;
  logic        rst_n_i      = 1'b0;
  logic [15:0] addr_i       = 16'h0000;
  logic [7:0]  wdata_i      = 8'h00;
  logic        wr_i         = 1'b0;
  logic        rd_i         = 1'b0;
  logic        opt_rc_en_i  = 1'b1;
  logic        opt_pll_en_i = 1'b0;
  logic        opt_pll_x8_i = 1'b0;
  logic        opt_rop_i    = 1'b1;
  logic        rc_clk_i     = 1'b0;
  logic        ext_clk_i    = 1'b0;
  logic        halt_i       = 1'b0;
  logic [7:0]  rdata_o;
  logic [7:0]  rc_trim_o;
  logic        osc_clk_o;
  logic        cpu_clk_o;
  logic        clk_out_o;
  logic        clk_out_oe_o;
  logic        pll_lock_flag_o;
  logic        irq_o;
  logic        osc_q        = 1'b0;
  logic        cpu_q        = 1'b0;
  int          hp_rc        = 4;
  int          hp_ext       = 5;
  int          n_rc         = 0;
  int          n_ext        = 0;
  int          osc_tg       = 0;
  int          cpu_tg       = 0;
  int          num_errors   = 0;
  int          checks       = 0;

  clk_ctrl #(.STARTUP_CYC(SU)) uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .opt_rc_en_i(opt_rc_en_i), .opt_pll_en_i(opt_pll_en_i), .opt_pll_x8_i(opt_pll_x8_i),
    .opt_rop_i(opt_rop_i), .rc_clk_i(rc_clk_i), .ext_clk_i(ext_clk_i), .halt_i(halt_i),
    .osc_clk_o(osc_clk_o), .cpu_clk_o(cpu_clk_o), .clk_out_o(clk_out_o),
    .clk_out_oe_o(clk_out_oe_o),
    .rc_trim_o(rc_trim_o), .pll_lock_flag_o(pll_lock_flag_o), .irq_o(irq_o));

  always #10 ref_clk_i = ~ref_clk_i;

  // two free sources at different rates so the selected one can be told apart
  always @(posedge ref_clk_i) begin
    n_rc <= (n_rc >= hp_rc - 1) ? 0 : n_rc + 1;
    n_ext <= (n_ext >= hp_ext - 1) ? 0 : n_ext + 1;
    if (n_rc >= hp_rc - 1) rc_clk_i <= ~rc_clk_i;
    if (n_ext >= hp_ext - 1) ext_clk_i <= ~ext_clk_i;
    osc_q <= osc_clk_o;
    cpu_q <= cpu_clk_o;
    if (osc_q !== osc_clk_o) osc_tg <= osc_tg + 1;
    if (cpu_q !== cpu_clk_o) cpu_tg <= cpu_tg + 1;
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rng(input string n, input int v, input int lo, input int hi);
    chk(n, 8'(v >= lo && v <= hi), 8'h01);
  endtask
  task automatic tmo(input bit hit);
    if (hit) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(n, rdata_o, e);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic win(input int c, output int d);
    int s;
    s = osc_tg;
    cyc(c);
    d = osc_tg - s;
  endtask
  // cpu half-period counted in oscillator edges
  task automatic half(output int d);
    int s;
    int o;
    s = cpu_tg;
    o = osc_tg;
    for (int i = 0; i < 400 && cpu_tg == s; i++) cyc(1);
    tmo(cpu_tg == s);
    d = osc_tg - o;
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    cyc(6);
    rst_n_i <= 1'b1;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    rc("ctrl", 16'h0038, 8'h00);
    rc("trim", 16'h0039, 8'hFF);
    rc("f5a", 16'h1000, clk_ctrl_pkg::FACTORY_5V_DEF);
    rc("f5b", 16'hFFDE, clk_ctrl_pkg::FACTORY_5V_DEF);
    rc("f3a", 16'h1001, clk_ctrl_pkg::FACTORY_3V_DEF);
    rc("f3b", 16'hFFDF, clk_ctrl_pkg::FACTORY_3V_DEF);
    wr(16'h0040, 8'h5A);
    rc("unmapped", 16'h0040, 8'h00);
    wr(16'h0038, 8'h03);
    rc("ctrl_rw", 16'h0038, 8'h03);
    wr(16'h0038, 8'h00);
    wr(16'h003D, 8'h01);
    rc("load5", 16'h0039, clk_ctrl_pkg::FACTORY_5V_DEF);
    wr(16'h003D, 8'h02);
    rc("load3", 16'h0039, clk_ctrl_pkg::FACTORY_3V_DEF);
    wr(16'h0039, 8'h55);
    rc("trim_w", 16'h0039, 8'h55);
    chk("trim_pin", rc_trim_o, 8'h55);
    do_reset();
    rc("trim_rst", 16'h0039, 8'hFF);
    chk("trim_pin_rst", rc_trim_o, 8'hFF);
  endtask
  task automatic t_src();
    int d;
    cyc(10);
    win(200, d);
    rng("rc_rate", d, 49, 51);
    opt_rc_en_i <= 1'b0;
    cyc(10);
    win(200, d);
    rng("ext_rate", d, 39, 41);
    opt_rc_en_i <= 1'b1;
    wr(16'h0038, 8'h02);
    cyc(2);
    chk("clk_out_oe", clk_out_oe_o, 8'h01);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      chk("clk_out", clk_out_o, osc_clk_o);
    end
    wr(16'h0038, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      chk("clk_out_off", {clk_out_oe_o, clk_out_o}, 8'h00);
    end
  endtask
  task automatic t_slow();
    int d;
    hp_rc = 2;
    cyc(10);
    for (int m = 0; m < 2; m++) begin
      wr(16'h0038, m ? 8'h00 : 8'h01);
      // the half running when the write lands is only seen from the write on, so it is not judged
      half(d);
      for (int i = 0; i < 4; i++) begin
        half(d);
        rng("half_len", d == 1 || d == 32, 1, 1);
      end
      chk("half_mode", d, m ? 8'h01 : 8'h20);
    end
  endtask
  task automatic t_pll();
    int i;
    int s;
    int d;
    hp_rc = 32;
    cyc(10);
    s = osc_tg;
    opt_pll_en_i <= 1'b1;
    for (i = 0; i < 100 && pll_lock_flag_o !== 1'b1; i++) cyc(1);
    tmo(i == 100);
    rng("startup", i, SU - 2, SU + 3);
    rng("withheld", osc_tg - s, 0, 1);
    rc("integ", 16'h003A, 8'h01);
    chk("irq_masked", irq_o, 8'h00);
    wr(16'h003C, 8'h01);
    cyc(2);
    chk("irq_lock", irq_o, 8'h01);
    wr(16'h003B, 8'h01);
    cyc(2);
    chk("irq_clr", irq_o, 8'h00);
    rc("stat_clr", 16'h003B, 8'h00);
    cyc(150);
    win(256, d);
    rng("pll_x4", d, 30, 34);
    opt_pll_x8_i <= 1'b1;
    cyc(150);
    win(256, d);
    rng("pll_x8", d, 62, 66);
    halt_i <= 1'b1;
    cyc(10);
    halt_i <= 1'b0;
    win(SU - 5, d);
    rng("wake_held", d, 0, 1);
    chk("wake_lock", pll_lock_flag_o, 8'h00);
    opt_pll_en_i <= 1'b0;
  endtask
  task automatic t_erase();
    opt_rop_i <= 1'b0;
    cyc(3);
    rc("er5a", 16'h1000, 8'hFF);
    rc("er5b", 16'hFFDE, 8'hFF);
    rc("er3a", 16'h1001, 8'hFF);
    rc("er3b", 16'hFFDF, 8'hFF);
    rc("er_stat", 16'h003B, 8'h02);
    wr(16'h003C, 8'h02);
    cyc(2);
    chk("irq_erase", irq_o, 8'h01);
  endtask

  initial begin
    do_reset();
    t_regs();
    t_src();
    t_slow();
    t_pll();
    t_erase();
    print_verdict();
  end
endmodule // clk_ctrl_test
